// ==== verilog/status_summary_regs.svh ====
`ifndef STATUS_SUMMARY_REGS_SVH
`define STATUS_SUMMARY_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define HOST_STATUS_OFS   8'h28
`define IRQ_MASK_OFS      8'h38

// ----------------------------------------
// flag, summary and encoded-field bit positions
// ----------------------------------------
`define BIT_TX_DONE       0
`define BIT_TX_STOPPED    1
`define BIT_TX_BUF_UNAV   2
`define BIT_TX_JABBER     3
`define BIT_TX_UNDERFLOW  5
`define BIT_RX_DONE       6
`define BIT_RX_BUF_UNAV   7
`define BIT_RX_STOPPED    8
`define BIT_RX_WATCHDOG   9
`define BIT_EARLY_TX      10
`define BIT_TIMER_EXP     11
`define BIT_FATAL_BUS     13
`define BIT_ABNORMAL_SUM  15
`define BIT_NORMAL_SUM    16
`define RX_STATE_LSB      17
`define TX_STATE_LSB      20
`define FAULT_CAUSE_LSB   23

// ----------------------------------------
// flag groups and reset values
// ----------------------------------------
`define NORMAL_SET        32'h0000_0045
`define ABNORMAL_SET      32'h0000_2faa
`define FLAG_SET          32'h0000_2fef
`define HOST_STATUS_RST   32'h0000_0000
`define IRQ_MASK_RST      32'h0000_0000

`endif

// ==== verilog/status_summary_pkg.sv ====
`default_nettype none

package status_summary_pkg;

  // ----------------------------------------
  // event pulses from the dma processes
  // ----------------------------------------
  typedef struct packed {
    logic tx_done;
    logic tx_stopped;
    logic tx_buf_unavail;
    logic tx_jabber;
    logic tx_underflow;
    logic rx_done;
    logic rx_buf_unavail;
    logic rx_stopped;
    logic rx_watchdog;
    logic early_tx;
    logic timer_expired;
  } proc_events_t;

  // ----------------------------------------
  // read-only encoded status fields
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] bus_fault_cause;
    logic [2:0] tx_process_state;
    logic [2:0] rx_process_state;
  } proc_view_t;

endpackage

`default_nettype wire

// ==== verilog/status_interrupt_summary.sv ====
// The implementer's own choices: the Wishbone interface to the registers and the address map.

`include "status_summary_regs.svh"

`default_nettype none

module status_interrupt_summary
  import status_summary_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  input  wire proc_events_t events_i,
  input  wire logic         sys_error_i,
  input  wire logic [2:0]   fault_cause_i,
  input  wire logic [2:0]   tx_state_i,
  input  wire logic [2:0]   rx_state_i,
  output logic              irq_o,
  output logic              bus_halt_o
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [31:0] event_vec(input proc_events_t e,
                                            input logic         fault);
    logic [31:0] v;
    v                    = 32'h0000_0000;
    v[`BIT_TX_DONE]      = e.tx_done;
    v[`BIT_TX_STOPPED]   = e.tx_stopped;
    v[`BIT_TX_BUF_UNAV]  = e.tx_buf_unavail;
    v[`BIT_TX_JABBER]    = e.tx_jabber;
    v[`BIT_TX_UNDERFLOW] = e.tx_underflow;
    v[`BIT_RX_DONE]      = e.rx_done;
    v[`BIT_RX_BUF_UNAV]  = e.rx_buf_unavail;
    v[`BIT_RX_STOPPED]   = e.rx_stopped;
    v[`BIT_RX_WATCHDOG]  = e.rx_watchdog;
    v[`BIT_EARLY_TX]     = e.early_tx;
    v[`BIT_TIMER_EXP]    = e.timer_expired;
    v[`BIT_FATAL_BUS]    = fault;
    event_vec            = v;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0] flags_r;
  logic [31:0] flags_nxt;
  logic [31:0] mask_r;
  logic [31:0] mask_nxt;
  proc_view_t  view_r;
  proc_view_t  view_nxt;
  logic        normal_sum_r;
  logic        normal_sum_nxt;
  logic        abnormal_sum_r;
  logic        abnormal_sum_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic        halt_r;
  logic        halt_nxt;
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  logic        bus_req;
  logic        hit_status;
  logic        hit_mask;
  logic [31:0] wr_lanes;
  logic [31:0] set_v;
  logic [31:0] clr_v;
  logic [31:0] open_flags;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // one request per ack: the cycle that shows ack is never taken again
  assign bus_req    = wb_cyc_i & wb_stb_i & ~ack_r;
  assign hit_status = (wb_adr_i[7:2] == 6'(`HOST_STATUS_OFS >> 2));
  assign hit_mask   = (wb_adr_i[7:2] == 6'(`IRQ_MASK_OFS >> 2));
  assign wr_lanes   = lane_mask(wb_sel_i);

  always_comb begin
    ack_nxt = bus_req;
  end

  // ----------------------------------------
  // mask register
  // ----------------------------------------
  always_comb begin
    mask_nxt = mask_r;
    if (bus_req && wb_we_i && hit_mask) begin
      // only flag positions carry a mask bit
      mask_nxt = ((mask_r & ~wr_lanes) | (wb_dat_i & wr_lanes))
                 & `FLAG_SET;
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  always_comb begin
    set_v = event_vec(events_i, sys_error_i);
    clr_v = 32'h0000_0000;
    if (bus_req && wb_we_i && hit_status) begin
      clr_v = wb_dat_i & wr_lanes;
    end
    if (events_i.tx_done) begin
      clr_v[`BIT_EARLY_TX] = 1'b1;
    end
    // set wins over any clear landing in the same cycle
    flags_nxt = ((flags_r & ~clr_v) | set_v) & `FLAG_SET;
  end

  // ----------------------------------------
  // summaries and interrupt request
  // ----------------------------------------
  always_comb begin
    // summary tracks the flags it will sit beside, so reads stay coherent
    open_flags       = flags_nxt & mask_nxt;
    normal_sum_nxt   = |(open_flags & `NORMAL_SET);
    abnormal_sum_nxt = |(open_flags & `ABNORMAL_SET);
    irq_nxt          = normal_sum_nxt | abnormal_sum_nxt;
  end

  // ----------------------------------------
  // encoded fields and bus halt
  // ----------------------------------------
  always_comb begin
    view_nxt                  = view_r;
    view_nxt.tx_process_state = tx_state_i;
    view_nxt.rx_process_state = rx_state_i;
    if (sys_error_i) begin
      view_nxt.bus_fault_cause = fault_cause_i;
    end
    // halt holds until device reset; clearing the flag does not resume
    halt_nxt = halt_r | sys_error_i;
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    if (bus_req) begin
      rdata_nxt = 32'h0000_0000;
      if (!wb_we_i && hit_status) begin
        // encoded fields only appear here, never in the summaries
        rdata_nxt                          = flags_r;
        rdata_nxt[`BIT_ABNORMAL_SUM]       = abnormal_sum_r;
        rdata_nxt[`BIT_NORMAL_SUM]         = normal_sum_r;
        rdata_nxt[`RX_STATE_LSB +: 3]      = view_r.rx_process_state;
        rdata_nxt[`TX_STATE_LSB +: 3]      = view_r.tx_process_state;
        rdata_nxt[`FAULT_CAUSE_LSB +: 3]   = view_r.bus_fault_cause;
      end else if (!wb_we_i && hit_mask) begin
        rdata_nxt = mask_r;
      end
    end
  end

  // ----------------------------------------
  // bus registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // mask registers
  // ----------------------------------------
  // reset closes every mask, so nothing interrupts before software opts in
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= `IRQ_MASK_RST;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // ----------------------------------------
  // flag registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= `HOST_STATUS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------
  // summary and interrupt registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      normal_sum_r   <= 1'b0;
      abnormal_sum_r <= 1'b0;
      irq_r          <= 1'b0;
    end else begin
      normal_sum_r   <= normal_sum_nxt;
      abnormal_sum_r <= abnormal_sum_nxt;
      irq_r          <= irq_nxt;
    end
  end

  // ----------------------------------------
  // field and halt registers
  // ----------------------------------------
  // halt clears only here: a stuck bus must not be retried by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      view_r <= '0;
      halt_r <= 1'b0;
    end else begin
      view_r <= view_nxt;
      halt_r <= halt_nxt;
    end
  end

  assign wb_ack_o   = ack_r;
  assign wb_dat_o   = rdata_r;
  assign irq_o      = irq_r;
  assign bus_halt_o = halt_r;

endmodule

`default_nettype wire

// ==== testbench/status_summary_props.sv ====
`default_nettype none
module status_summary_props
  import status_summary_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         wb_cyc_i,
  input wire logic         wb_stb_i,
  input wire logic         wb_we_i,
  input wire logic [31:0]  wb_dat_o,
  input wire logic         wb_ack_o,
  input wire proc_events_t events_i,
  input wire logic         sys_error_i,
  input wire logic         irq_o,
  input wire logic         bus_halt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_rd_ack; wb_ack_o && !wb_we_i; endsequence
  AST_ACK_NEXT: assert property (s_req |=> wb_ack_o)
    else $error("ack missing");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_HALT_SET: assert property (sys_error_i |=> bus_halt_o)
    else $error("halt missing");
  AST_HALT_KEEP: assert property (bus_halt_o |=> bus_halt_o)
    else $error("halt released");
  AST_HALT_CAUSE: assert property ($rose(bus_halt_o) |-> $past(sys_error_i))
    else $error("halt without error");
  AST_IRQ_RISE: assert property ($rose(irq_o) |->
    $past(|events_i || sys_error_i || (wb_we_i && wb_cyc_i)))
    else $error("irq without cause");
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(wb_we_i && wb_cyc_i))
    else $error("irq fell without write");
  AST_RD_NORM: assert property (s_rd_ack ##0 wb_dat_o[16] |-> |(wb_dat_o & 32'h45))
    else $error("normal summary without flag");
  AST_RD_ABN: assert property (s_rd_ack ##0 wb_dat_o[15] |-> |(wb_dat_o & 32'h2faa))
    else $error("abnormal summary without flag");
  AST_RD_ZERO: assert property (s_rd_ack |-> wb_dat_o[31:26] == 6'h00 && !wb_dat_o[14])
    else $error("reserved bits set");
endmodule
bind status_interrupt_summary status_summary_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .events_i(events_i),
  .sys_error_i(sys_error_i), .irq_o(irq_o), .bus_halt_o(bus_halt_o));
`default_nettype wire

// ==== testbench/wb_host_model.sv ====
`default_nettype none
module wb_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] din_i,
  output var  logic        cyc_o,
  output var  logic        stb_o,
  output var  logic        we_o,
  output var  logic [7:0]  adr_o,
  output var  logic [3:0]  sel_o,
  output var  logic [31:0] dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end
  // waits for ack without a limit; the bench timeout cuts a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = din_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ==== testbench/test_status_interrupt_summary.sv ====
`default_nettype none
module test_status_interrupt_summary
  import status_summary_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, cyc, stb, we, ack, irq, halt, sys_err;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [2:0] cause, txs, rxs;
  proc_events_t ev;
  int n_mismatch, n_compared, cycles;
  wb_host_model u_host (.clk_i(clk_i), .ack_i(ack), .din_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  status_interrupt_summary u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .events_i(ev), .sys_error_i(sys_err),
    .fault_cause_i(cause), .tx_state_i(txs), .rx_state_i(rxs), .irq_o(irq),
    .bus_halt_o(halt));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    u_host.xfer(1'b0, a, 4'hf, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, 4'hf, d, q);
  endtask
  task automatic wrs(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    u_host.xfer(1'b1, a, s, d, q);
  endtask
  task automatic pulse(input proc_events_t e);
    ev <= e;
    @(posedge clk_i);
    ev <= '0;
  endtask
  task automatic t_reset();
    rd(8'h28, 32'h0);
    rd(8'h38, 32'h0);
    rd(8'h3c, 32'h0);
    wr(8'h38, 32'hffff_ffff);
    rd(8'h38, 32'h0000_2fef);
  endtask
  task automatic t_normal();
    pulse('{tx_done: 1'b1, default: 1'b0});
    rd(8'h28, 32'h0001_0001);
    rd(8'h28, 32'h0001_0001);
    chk({31'h0, irq}, 32'h1);
    wr(8'h28, 32'h0000_fffe);
    rd(8'h28, 32'h0001_0001);
    wr(8'h28, 32'h1);
    rd(8'h28, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_early();
    pulse('{early_tx: 1'b1, default: 1'b0});
    rd(8'h28, 32'h0000_8400);
    pulse('{tx_done: 1'b1, default: 1'b0});
    rd(8'h28, 32'h0001_0001);
    pulse('{timer_expired: 1'b1, default: 1'b0});
    wr(8'h28, 32'h1);
    rd(8'h28, 32'h0000_8800);
    wr(8'h28, 32'hffff_ffff);
  endtask
  task automatic t_masked();
    wr(8'h38, 32'h0);
    pulse('{rx_done: 1'b1, default: 1'b0});
    rd(8'h28, 32'h0000_0040);
    chk({31'h0, irq}, 32'h0);
    wr(8'h38, 32'h0000_0040);
    chk({31'h0, irq}, 32'h1);
    wr(8'h28, 32'hffff_ffff);
  endtask
  task automatic t_fatal();
    wr(8'h38, 32'h0000_2fef);
    {txs, rxs, cause, sys_err} <= {3'h5, 3'h3, 3'h6, 1'b1};
    @(posedge clk_i);
    sys_err <= 1'b0;
    rd(8'h28, 32'h0356_a000);
    chk({31'h0, halt}, 32'h1);
    wr(8'h28, 32'h0000_2000);
    rd(8'h28, 32'h0356_0000);
  endtask
  task automatic t_lanes();
    wr(8'h38, 32'h0000_0045);
    pulse('{tx_stopped: 1'b1, tx_jabber: 1'b1, tx_underflow: 1'b1, rx_buf_unavail: 1'b1,
           rx_stopped: 1'b1, rx_watchdog: 1'b1, early_tx: 1'b1, timer_expired: 1'b1,
           default: 1'b0});
    rd(8'h28, 32'h0356_0faa);
    chk({31'h0, irq}, 32'h0);
    wrs(8'h38, 4'h2, 32'hffff_ffff);
    rd(8'h38, 32'h0000_2f45);
    rd(8'h28, 32'h0356_8faa);
    chk({31'h0, irq}, 32'h1);
    wr(8'h28, 32'hffff_ffff);
    rd(8'h28, 32'h0356_0000);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    {rst_i, sys_err, cause, txs, rxs, ev, cycles} = {1'b1, 21'h0, 32'h0};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_normal();
    t_early();
    t_masked();
    t_fatal();
    t_lanes();
    finish_test();
  end
endmodule
`default_nettype wire
